// ==== rtl/vric_pkg.sv ====
// Purpose: Constants for the vendor register bank with the ID resistor converter
// Assumes: 100 MHz register clock
// Notes:   Addresses are full 8-bit extended addresses; immediate ones zero-extend
package vric_pkg;
	// Register addresses
	localparam logic [7:0] VRIC_ADDR_CK_STAT  = 8'h20;
	localparam logic [7:0] VRIC_ADDR_CK_LATCH = 8'h21;
	localparam logic [7:0] VRIC_ADDR_BOOST    = 8'h31;
	localparam logic [7:0] VRIC_ADDR_AUDIO    = 8'h33;
	localparam logic [7:0] VRIC_ADDR_CONV_WR  = 8'h36;
	localparam logic [7:0] VRIC_ADDR_CONV_SET = 8'h37;
	localparam logic [7:0] VRIC_ADDR_CONV_CLR = 8'h38;
	// Field positions
	localparam int VRIC_BOOST_LSB       = 5;
	localparam int VRIC_CONV_CODE_LSB   = 0;
	localparam int VRIC_CONV_DONE_BIT   = 3;
	localparam int VRIC_CONV_TRIG_BIT   = 4;
	localparam int VRIC_CONV_RSVD_BIT   = 5;
	localparam int VRIC_CONV_IRQEN_BIT  = 6;
	localparam int VRIC_STAT_CODE_LSB   = 3;
	localparam int VRIC_STAT_DONE_BIT   = 6;
	localparam int VRIC_LATCH_CONV_BIT  = 3;
	// Set/clear mask of the conversion register (bits 6:4)
	localparam logic [7:0] VRIC_CONV_SC_MASK = 8'h70;
	// Reset values and codes
	localparam logic [1:0] VRIC_BOOST_RST    = 2'h0;
	localparam logic [3:0] VRIC_AUDIO_RST    = 4'h0;
	localparam logic [3:0] VRIC_AUDIO_KEY    = 4'hA;
	localparam logic [2:0] VRIC_CODE_RST     = 3'h0;
	localparam logic [1:0] VRIC_BOOST_7P4    = 2'h2;
	localparam logic [1:0] VRIC_BOOST_3P7    = 2'h3;
	// Conversion time
	localparam int VRIC_CLK_PERIOD_NS = 10;
	localparam int VRIC_CONV_TIME_NS  = 282000;
	localparam int VRIC_CONV_CYCLES   =
		(VRIC_CONV_TIME_NS + VRIC_CLK_PERIOD_NS - 1) / VRIC_CLK_PERIOD_NS;
	// Converter sequencer states
	typedef enum logic [1:0] {
		VRIC_ST_IDLE = 2'b01,
		VRIC_ST_CONV = 2'b10
	} vric_state_e;
endpackage

// ==== rtl/vric_regs.sv ====
// Purpose: Vendor register bank: drive boost, headset unlock, ID resistor converter
// Assumes: Register strobes come from the ULPI register engine on clk_i
// Notes:   Read data is registered and valid one cycle after reg_rd_i
//
// Summary of operation
// - Immediate registers also reachable by extended address
// - Vendor registers sit at 30h to 3Fh
// - Boost code 10b/11b raises drive, 00b none
// - Headset audio only when key equals 1010
// - Three-bit code encodes measured ID resistance
// - Code mirrored in carkit interrupt status
// - Complete flag set after 282 us conversion
// - Reading conversion register clears complete flag
// - Carkit status read leaves complete flag set
// - Trigger starts conversion, self-clears on completion
// - Enabled completion with the complete flag clear raises alt_int indication
// - Enable is OR of both enable bits
// - Write, set, clear at 36h, 37h, 38h
// - Latch bit sets on enabled rise, read-clears
`timescale 1ns/100ps
module vric_regs #(
	parameter int CONV_CYCLES = vric_pkg::VRIC_CONV_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	input  wire logic       carkit_irq_en_i,
	input  wire logic [2:0] id_meas_code_i,
	output logic      [1:0] hs_boost_o,
	output logic            hs_boost_active_o,
	output logic            headset_audio_en_o,
	output logic            conv_busy_o,
	output logic            id_conv_complete_o,
	output logic            alt_int_o
);
	import vric_pkg::*;

	localparam int CW = $clog2(CONV_CYCLES + 1);

	logic [1:0]  boost_ff;
	logic [3:0]  headset_audio_key_ff;
	logic [2:0]  id_resistance_code_ff;
	logic        id_conv_complete_ff;
	logic        id_conv_trigger_ff;
	logic        rsvd5_ff;
	logic        id_conv_irq_enable_ff;
	logic        id_conv_event_latch_ff;
	logic        alt_int_ff;
	logic [7:0]  rdata_ff;
	logic        rvalid_ff;
	logic [CW-1:0] cnt_ff;
	vric_state_e state_ff;
	vric_state_e nxt_state;

	// Address decode; full 8-bit compare serves both access kinds
	wire hit_boost = reg_addr_i == VRIC_ADDR_BOOST;
	wire hit_audio = reg_addr_i == VRIC_ADDR_AUDIO;
	wire hit_cwr   = reg_addr_i == VRIC_ADDR_CONV_WR;
	wire hit_cset  = reg_addr_i == VRIC_ADDR_CONV_SET;
	wire hit_cclr  = reg_addr_i == VRIC_ADDR_CONV_CLR;
	wire hit_conv  = hit_cwr | hit_cset | hit_cclr;
	wire hit_stat  = reg_addr_i == VRIC_ADDR_CK_STAT;
	wire hit_latch = reg_addr_i == VRIC_ADDR_CK_LATCH;

	// Current image of the conversion register
	wire [7:0] conv_img = {1'b0, id_conv_irq_enable_ff, rsvd5_ff, id_conv_trigger_ff,
		id_conv_complete_ff, id_resistance_code_ff};

	// Write, set and clear for the conversion register; set/clear touch bits 6:4 only
	wire [7:0] sc_set  = reg_wdata_i & VRIC_CONV_SC_MASK;
	wire [7:0] conv_nw = hit_cwr  ? reg_wdata_i :
			     hit_cset ? (conv_img | sc_set) :
			     (conv_img & ~sc_set);
	wire conv_wr = reg_wr_i & hit_conv;

	// Converter events
	wire conv_end   = (state_ff == VRIC_ST_CONV) && (cnt_ff == CW'(1));
	wire trig_next  = conv_wr ? conv_nw[VRIC_CONV_TRIG_BIT] : id_conv_trigger_ff;
	wire conv_start = (state_ff == VRIC_ST_IDLE) && trig_next && !id_conv_trigger_ff;
	wire irq_en_eff = id_conv_irq_enable_ff | carkit_irq_en_i;
	wire done_rise  = conv_end && !id_conv_complete_ff;
	// Only the conversion register read clears the flag, never the status read
	wire done_rdclr = reg_rd_i & hit_conv;

	// Read mux
	wire [7:0] rd_mux =
		hit_boost ? {1'b0, boost_ff, 5'h00} :
		hit_audio ? {4'h0, headset_audio_key_ff} :
		hit_conv  ? conv_img :
		hit_stat  ? {1'b0, id_conv_complete_ff, id_resistance_code_ff, 3'h0} :
		hit_latch ? {4'h0, id_conv_event_latch_ff, 3'h0} :
		8'h00;

	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			VRIC_ST_IDLE: begin
				if (conv_start) begin
					nxt_state = VRIC_ST_CONV;
				end
			end
			VRIC_ST_CONV: begin
				if (conv_end) begin
					nxt_state = VRIC_ST_IDLE;
				end
			end
			default: nxt_state = VRIC_ST_IDLE;
		endcase
	end

	// Sequencer state and conversion timer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= VRIC_ST_IDLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= conv_start ? CW'(CONV_CYCLES) :
				    (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;
		end
	end

	// Plain read/write registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			boost_ff             <= VRIC_BOOST_RST;
			headset_audio_key_ff <= VRIC_AUDIO_RST;
		end else begin
			if (reg_wr_i && hit_boost) begin
				boost_ff <= reg_wdata_i[VRIC_BOOST_LSB +: 2];
			end
			if (reg_wr_i && hit_audio) begin
				headset_audio_key_ff <= reg_wdata_i[3:0];
			end
		end
	end

	// Conversion register fields; hardware completion beats a same-cycle trigger write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_resistance_code_ff <= VRIC_CODE_RST;
			id_conv_trigger_ff    <= 1'b0;
			rsvd5_ff              <= 1'b0;
			id_conv_irq_enable_ff <= 1'b0;
		end else begin
			if (conv_end) begin
				id_resistance_code_ff <= id_meas_code_i;
			end else if (reg_wr_i && hit_cwr) begin
				id_resistance_code_ff <= reg_wdata_i[2:0];
			end
			id_conv_trigger_ff <= conv_end ? 1'b0 : trig_next;
			if (conv_wr) begin
				rsvd5_ff              <= conv_nw[VRIC_CONV_RSVD_BIT]; // link keeps 0
				id_conv_irq_enable_ff <= conv_nw[VRIC_CONV_IRQEN_BIT];
			end
		end
	end

	// Complete flag and event latch; a set in the clearing cycle wins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_conv_complete_ff    <= 1'b0;
			id_conv_event_latch_ff <= 1'b0;
			alt_int_ff             <= 1'b0;
		end else begin
			id_conv_complete_ff    <= conv_end | (id_conv_complete_ff & ~done_rdclr);
			id_conv_event_latch_ff <= (done_rise & irq_en_eff) |
				(id_conv_event_latch_ff & ~(reg_rd_i & hit_latch));
			alt_int_ff             <= done_rise & irq_en_eff;
		end
	end

	// Registered read data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// Outputs; reserved boost code 01b gives no boost
	assign hs_boost_o         = boost_ff;
	assign hs_boost_active_o  = (boost_ff == VRIC_BOOST_7P4) || (boost_ff == VRIC_BOOST_3P7);
	assign headset_audio_en_o = headset_audio_key_ff == VRIC_AUDIO_KEY;
	assign conv_busy_o        = state_ff == VRIC_ST_CONV;
	assign id_conv_complete_o = id_conv_complete_ff;
	assign alt_int_o          = alt_int_ff;
	assign reg_rdata_o        = rdata_ff;
	assign reg_rvalid_o       = rvalid_ff;

	// Assertions; helper count of cycles since the last start, kept apart from the
	// Down-counter so a wrong load value or a stuck timer shows up as a mismatch
	logic [CW-1:0] conv_age_ff;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			conv_age_ff <= '0;
		end else if (conv_start) begin
			conv_age_ff <= CW'(1);
		end else if (conv_busy_o) begin
			conv_age_ff <= conv_age_ff + CW'(1);
		end else begin
			conv_age_ff <= '0;
		end
	end

	// Conversion steps; the full conversion time is far too long for a plain delay
	sequence s_start;
		conv_start;
	endsequence
	sequence s_finish;
		id_conv_complete_ff && !conv_busy_o;
	endsequence

	a_conv_duration: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_end |-> conv_age_ff == CW'(CONV_CYCLES) ##1 s_finish)
		else $error("conversion did not complete after set time");
	a_conv_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_busy_o |-> conv_age_ff <= CW'(CONV_CYCLES))
		else $error("conversion ran past set time");
	a_trig_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_start |=> conv_busy_o && id_conv_trigger_ff)
		else $error("start did not raise busy and trigger");
	a_no_abort: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_busy_o && !conv_end |=> conv_busy_o)
		else $error("conversion stopped early");
	a_trig_selfclr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_end |=> !id_conv_trigger_ff && id_conv_complete_ff)
		else $error("trigger not cleared at completion");
	a_code_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_end |=> id_resistance_code_ff == $past(id_meas_code_i))
		else $error("code not loaded with flag");
	a_rdclr_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && hit_conv && !conv_end |=> !id_conv_complete_ff)
		else $error("conversion register read did not clear flag");
	a_stat_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && hit_stat && id_conv_complete_ff |=> id_conv_complete_ff)
		else $error("status read cleared flag");
	a_alt_int: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		conv_end && !id_conv_complete_ff && (id_conv_irq_enable_ff || carkit_irq_en_i)
		|=> alt_int_o)
		else $error("alt_int missing on enabled completion");
	a_latch_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alt_int_o |-> id_conv_event_latch_ff)
		else $error("latch not set with interrupt");
	a_audio_key: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && hit_audio
		|=> headset_audio_en_o == ($past(reg_wdata_i[3:0]) == VRIC_AUDIO_KEY))
		else $error("audio enable does not follow key");
	a_stat_mirror: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && hit_stat |=> reg_rdata_o[5:3] == $past(id_resistance_code_ff))
		else $error("status mirror differs from code");
	a_set_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && hit_cset && reg_wdata_i[6] |=> id_conv_irq_enable_ff)
		else $error("set access did not set enable");
	a_boost_rsvd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		boost_ff == 2'h1 |-> !hs_boost_active_o)
		else $error("reserved boost code active");

	// Bus answer: one-cycle valid pulse, data frozen between reads
	a_rd_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered next cycle");
	a_rvalid_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rvalid_o |-> $past(reg_rd_i))
		else $error("read valid without read strobe");
	a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!reg_rvalid_o |-> $stable(reg_rdata_o))
		else $error("read data moved between reads");

	// Register loads and mirrors seen one cycle after the access
	a_boost_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && hit_boost
		|=> hs_boost_o == $past(reg_wdata_i[VRIC_BOOST_LSB +: 2]))
		else $error("boost field not loaded");
	a_stat_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && hit_stat
		|=> reg_rdata_o[VRIC_STAT_DONE_BIT] == $past(id_conv_complete_ff))
		else $error("status mirror differs from flag");

	// Interrupt path: only an enabled completion pulses, and a latch read empties it
	a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alt_int_o |-> $past(irq_en_eff))
		else $error("interrupt without any enable");
	a_latch_rdclr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && hit_latch && !(done_rise && irq_en_eff)
		|=> !id_conv_event_latch_ff)
		else $error("latch not cleared by its read");
	a_irq_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alt_int_o |=> !alt_int_o)
		else $error("interrupt pulse longer than one cycle");
endmodule

// ==== tb/vric_link_model.sv ====
// Purpose: Link-side model that issues register reads and writes
// Assumes: One request per call, strobes one cycle long
// Notes:   An idle bus shows the inverse of the last address; write data is inverted after a write, left stale after a read
`timescale 1ns/100ps
module vric_link_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	// Quiet bus at time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// Immediate write; bit 5 of the conversion register always goes out as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] dd;
		dd = (a >= 8'h36 && a <= 8'h38) ? (d & 8'hDF) : d;
		@(posedge clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= dd;
		reg_wr_o    <= 1'b1;
		@(posedge clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~dd;
	endtask
	// Immediate read; a missing answer leaves unknown data so the compare fails
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		d = 8'hXX;
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		for (int i = 0; i < 3; i++) begin
			#1;
			if (reg_rvalid_i === 1'b1) begin
				d = reg_rdata_i;
				break;
			end
			@(posedge clk_i);
		end
	endtask
endmodule

// ==== tb/vric_regs_tb.sv ====
// Purpose: Self-checking bench for the vendor register bank
// Assumes: Conversion shortened to 20 cycles
// Notes:   Table rows cover plain registers; conversions are hand-written
`timescale 1ns/100ps
module vric_regs_tb;
	import vric_pkg::*;
	localparam int CONV = 20;
	typedef struct packed {logic [7:0] a, d, rd; logic [1:0] b; logic act, aud;} vric_row_s;
	logic       clk_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic       carkit_irq_en_i = 1'b0;
	logic [2:0] id_meas_code_i = 3'h0;
	logic       reg_wr_i, reg_rd_i, reg_rvalid_o, hs_boost_active_o, headset_audio_en_o;
	logic       conv_busy_o, id_conv_complete_o, alt_int_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
	logic [1:0] hs_boost_o;
	int         fails = 0;
	int         checks_done = 0;
	// Address, write data, read back, boost, boost active, audio enable
	vric_row_s rows [10] = '{
		'{8'h31, 8'h40, 8'h40, 2'h2, 1'b1, 1'b0}, '{8'h31, 8'h60, 8'h60, 2'h3, 1'b1, 1'b0},
		'{8'h31, 8'h20, 8'h20, 2'h1, 1'b0, 1'b0}, '{8'h31, 8'hFF, 8'h60, 2'h3, 1'b1, 1'b0},
		'{8'h31, 8'h00, 8'h00, 2'h0, 1'b0, 1'b0}, '{8'h33, 8'h0A, 8'h0A, 2'h0, 1'b0, 1'b1},
		'{8'h33, 8'hFB, 8'h0B, 2'h0, 1'b0, 1'b0}, '{8'h33, 8'h09, 8'h09, 2'h0, 1'b0, 1'b0},
		'{8'h20, 8'hFF, 8'h00, 2'h0, 1'b0, 1'b0}, '{8'h3F, 8'h55, 8'h00, 2'h0, 1'b0, 1'b0}};
	vric_regs #(.CONV_CYCLES(CONV)) vric_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.carkit_irq_en_i(carkit_irq_en_i), .id_meas_code_i(id_meas_code_i),
		.hs_boost_o(hs_boost_o), .hs_boost_active_o(hs_boost_active_o),
		.headset_audio_en_o(headset_audio_en_o), .conv_busy_o(conv_busy_o),
		.id_conv_complete_o(id_conv_complete_o), .alt_int_o(alt_int_o));
	vric_link_model vric_link_model_i (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o),
		.reg_rvalid_i(reg_rvalid_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	// Compare with case inequality so unknowns never match
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic results;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One conversion from start to flag clear; code held steady before completion
	task automatic conv(input logic [7:0] a, w, input logic ck, input logic [2:0] code,
		input logic alt, input logic [7:0] e21, e36);
		int n;
		@(posedge clk_i);
		carkit_irq_en_i <= ck;
		id_meas_code_i  <= code;
		vric_link_model_i.wr(a, w);
		#1;
		check(8'(conv_busy_o), 8'h01);
		n = 0;
		while (id_conv_complete_o !== 1'b1 && n < CONV + 10) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		check(8'(n), 8'(CONV));
		check(8'(alt_int_o), 8'(alt));
		check(8'(conv_busy_o), 8'h00);
		vric_link_model_i.rd(8'h20, d);
		check(d, {2'b01, code, 3'b000});
		check(8'(alt_int_o), 8'h00);
		vric_link_model_i.rd(8'h21, d);
		check(d, e21);
		vric_link_model_i.rd(8'h36, d);
		check(d, e36);
		vric_link_model_i.rd(8'h20, d);
		check(d, {2'b00, code, 3'b000});
	endtask
	// Main sequence: reset, table, conversions, reset in mid conversion
	initial begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		check(8'({hs_boost_o, hs_boost_active_o, headset_audio_en_o, conv_busy_o,
			id_conv_complete_o, alt_int_o}), 8'h00);
		vric_link_model_i.rd(8'h36, d);
		check(d, 8'h00);
		foreach (rows[i]) begin
			vric_link_model_i.wr(rows[i].a, rows[i].d);
			vric_link_model_i.rd(rows[i].a, d);
			check(d, rows[i].rd);
			check(8'({hs_boost_o, hs_boost_active_o, headset_audio_en_o}),
				8'({rows[i].b, rows[i].act, rows[i].aud}));
		end
		conv(8'h37, 8'h50, 1'b0, 3'h5, 1'b1, 8'h08, 8'h4D);
		vric_link_model_i.wr(8'h38, 8'h40);
		vric_link_model_i.rd(8'h36, d);
		check(d, 8'h05);
		conv(8'h36, 8'h10, 1'b1, 3'h7, 1'b1, 8'h08, 8'h0F);
		conv(8'h36, 8'h10, 1'b0, 3'h1, 1'b0, 8'h00, 8'h09);
		vric_link_model_i.wr(8'h36, 8'h10);
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b0;
		#1;
		check(8'({conv_busy_o, id_conv_complete_o}), 8'h00);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		vric_link_model_i.rd(8'h36, d);
		check(d, 8'h00);
		results();
	end
	// Watchdog: whole sequence needs well under 1000 cycles
	initial begin
		#(2000 * 10);
		fails++;
		results();
	end
endmodule
